// ==== core/sps_pkg.sv ====
// constants, register map and state types for the serial port block
// assumes one clock, which is also the oscillator the bit-rate divider counts

package sps_pkg;

  // ****************************************************************
  // register map (word index on the bus)
  // ****************************************************************
  localparam logic [7:0] IDX_SERIAL_BUFFER  = 8'h13;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h14;
  localparam logic [7:0] IDX_SERIAL_STATUS  = 8'h94;
  localparam logic [7:0] IDX_PIN_DIRECTION  = 8'h15;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned CTL_WRITE_COLLISION = 7;
  localparam int unsigned CTL_RX_OVERFLOW     = 6;
  localparam int unsigned CTL_PORT_ENABLE     = 5;
  localparam int unsigned CTL_CLOCK_POLARITY  = 4;
  localparam int unsigned STS_BUFFER_FULL     = 0;
  localparam int unsigned DIR_SCK_INPUT       = 0;
  localparam int unsigned DIR_SDI_INPUT       = 1;
  localparam int unsigned DIR_SDO_INPUT       = 2;
  localparam int unsigned DIR_SS_INPUT        = 3;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
  localparam logic [7:0] SERIAL_STATUS_RST  = 8'h00;
  localparam logic [7:0] SERIAL_BUFFER_RST  = 8'h00;
  localparam logic [3:0] PIN_DIRECTION_RST  = 4'hF;

  // ****************************************************************
  // bit timing: fastest setting gives 5 MHz from a 20 MHz oscillator
  // ****************************************************************
  localparam int unsigned OSC_REF_MHZ     = 20;
  localparam int unsigned MAX_BIT_MHZ     = 5;
  localparam int unsigned HALF_BIT_DIV4   = OSC_REF_MHZ / MAX_BIT_MHZ / 2;
  localparam int unsigned HALF_BIT_DIV16  = 4 * HALF_BIT_DIV4;
  localparam int unsigned HALF_BIT_DIV64  = 16 * HALF_BIT_DIV4;
  localparam logic [4:0]  DIV4_LAST       = 5'(HALF_BIT_DIV4 - 1);
  localparam logic [4:0]  DIV16_LAST      = 5'(HALF_BIT_DIV16 - 1);
  localparam logic [4:0]  DIV64_LAST      = 5'(HALF_BIT_DIV64 - 1);
  localparam logic [2:0]  LAST_BIT_INDEX  = 3'h7;

  typedef enum logic [3:0] {
    MODE_MASTER_DIV4  = 4'h0,
    MODE_MASTER_DIV16 = 4'h1,
    MODE_MASTER_DIV64 = 4'h2,
    MODE_MASTER_TIMER = 4'h3,
    MODE_SLAVE_SELECT = 4'h4,
    MODE_SLAVE_FREE   = 4'h5
  } sps_mode_t;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_LEAD  = 2'b01,
    MS_TRAIL = 2'b11
  } sps_mstate_t;

endpackage

// ==== core/sps_serial_port.sv ====
// SPI serial port: 8-bit shift register, receive buffer, master/slave
// assumes an Avalon-MM master on i_clock; pins arrive unsynchronised
//
// What this block does
// - eight bits per transfer, MSB first, duplex
// - full byte goes to buffer, flags set; in slave mode with buffer full the buffer keeps its old byte
// - next byte may shift before buffer read
// - write during transfer dropped, collision flag set
// - reading the buffer clears buffer-full flag
// - master mode never sets overflow flag
// - enable bit hands pins to serial port
// - polarity bit sets clock idle level
// - drive on one edge, sample opposite
// - master rate osc/4, /16, /64, timer/2
// - fastest master clock is a quarter oscillator
// - master write starts transfer, clock generated
// - master with clock input keeps receiving
// - slave shifts on external clock, flags
// - slave works in sleep, byte wakes
// - select pin only in mode 4, input
// - select low enables shifting, drives data-out
// - select high floats data-out mid byte
// - select low again resumes same bit
// - data-out as input stops driving it
// - shift register reached only through buffer

`timescale 1ns/1ps
`default_nettype none

module sps_serial_port
  import sps_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output var  logic [31:0] o_avs_readdata,
  output      logic        o_avs_waitrequest,
  input  wire logic        i_sck,
  output var  logic        o_sck,
  output      logic        o_sck_oe_n,
  input  wire logic        i_sdi,
  output var  logic        o_sdo,
  output      logic        o_sdo_oe_n,
  input  wire logic        i_slave_select_n,
  input  wire logic        i_timer_tick,
  input  wire logic        i_sleep,
  output      logic        o_serial_pins_active,
  output var  logic        o_port_interrupt_flag,
  output var  logic        o_wake
);

  // ****************************************************************
  // registers and shared state
  // ****************************************************************
  logic [7:0]  serial_buffer;
  logic [7:0]  serial_shift_reg;
  logic [2:0]  bit_index;
  logic        write_collision_flag;
  logic        receive_overflow_flag;
  logic        port_enable_bit;
  logic        clock_polarity_bit;
  logic [3:0]  mode_select;
  logic        buffer_full_flag;
  logic [3:0]  pin_direction;
  logic        access_ack;
  sps_mstate_t mst_state;
  sps_mstate_t next_mst_state;
  logic [4:0]  div_count;
  logic [4:0]  div_last;
  logic        sck_meta;
  logic        sck_sync;
  logic        sck_prev;
  logic        sdi_meta;
  logic        sdi_sync;
  logic        ss_meta;
  logic        ss_sync_n;

  logic        request;
  logic        rd_take;
  logic        wr_take;
  logic        buf_write;
  logic        buf_write_ok;
  logic        ctl_write;
  logic        mode_valid;
  logic        port_on;
  logic        master_en;
  logic        slave_en;
  logic        in_progress;
  logic        ss_controls;
  logic        ss_active;
  logic        half_tick;
  logic        lead_pulse;
  logic        trail_pulse;
  logic        sample_late;
  logic        shift_pulse;
  logic        slave_edge;
  logic        byte_done;
  logic [7:0]  new_byte;

  // ****************************************************************
  // bus slave: every access answers on its second cycle
  // ****************************************************************
  assign request           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = request & ~access_ack;
  assign rd_take           = i_avs_read & access_ack;
  assign wr_take           = i_avs_write & access_ack & i_avs_byteenable[0];
  assign buf_write         = wr_take & (i_avs_address == IDX_SERIAL_BUFFER);
  assign ctl_write         = wr_take & (i_avs_address == IDX_SERIAL_CONTROL);
  assign buf_write_ok      = buf_write & ~in_progress;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      access_ack <= 1'b0;
    end else begin
      access_ack <= request & ~access_ack;
    end
  end

  // read data settles in the first cycle and stands at the answering edge
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !access_ack) begin
      unique case (i_avs_address)
        IDX_SERIAL_BUFFER:  o_avs_readdata <= {24'h00_0000, serial_buffer};
        IDX_SERIAL_CONTROL: o_avs_readdata <= {24'h00_0000, write_collision_flag,
                                               receive_overflow_flag, port_enable_bit,
                                               clock_polarity_bit, mode_select};
        IDX_SERIAL_STATUS:  o_avs_readdata <= {31'h0000_0000, buffer_full_flag};
        IDX_PIN_DIRECTION:  o_avs_readdata <= {28'h000_0000, pin_direction};
        default:            o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // control and direction registers
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_enable_bit    <= SERIAL_CONTROL_RST[CTL_PORT_ENABLE];
      clock_polarity_bit <= SERIAL_CONTROL_RST[CTL_CLOCK_POLARITY];
      mode_select        <= SERIAL_CONTROL_RST[3:0];
    end else if (ctl_write) begin
      port_enable_bit    <= i_avs_writedata[CTL_PORT_ENABLE];
      clock_polarity_bit <= i_avs_writedata[CTL_CLOCK_POLARITY];
      mode_select        <= i_avs_writedata[3:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_direction <= PIN_DIRECTION_RST;
    end else if (wr_take && i_avs_address == IDX_PIN_DIRECTION) begin
      pin_direction <= i_avs_writedata[3:0];
    end
  end

  // ****************************************************************
  // mode decode
  // ****************************************************************
  // codes outside the six serial modes leave the port inert
  assign mode_valid  = (mode_select <= MODE_SLAVE_FREE);
  assign port_on     = port_enable_bit & mode_valid;
  assign master_en   = port_on & (mode_select <= MODE_MASTER_TIMER);
  assign slave_en    = port_on & ~master_en;
  assign ss_controls = (mode_select == MODE_SLAVE_SELECT) & pin_direction[DIR_SS_INPUT];
  assign ss_active   = ~ss_controls | ~ss_sync_n;
  assign in_progress = master_en ? ((mst_state != MS_IDLE) | sample_late)
                                 : (bit_index != 3'h0);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_meta  <= 1'b0;
      sck_sync  <= 1'b0;
      sck_prev  <= 1'b0;
      sdi_meta  <= 1'b0;
      sdi_sync  <= 1'b0;
      ss_meta   <= 1'b1;
      ss_sync_n <= 1'b1;
    end else begin
      sck_meta  <= i_sck;
      sck_sync  <= sck_meta;
      sck_prev  <= sck_sync;
      sdi_meta  <= i_sdi;
      sdi_sync  <= sdi_meta;
      ss_meta   <= i_slave_select_n;
      ss_sync_n <= ss_meta;
    end
  end

  // ****************************************************************
  // master bit-rate divider
  // ****************************************************************
  always_comb begin
    unique case (mode_select)
      MODE_MASTER_DIV16: div_last = DIV16_LAST;
      MODE_MASTER_DIV64: div_last = DIV64_LAST;
      default:           div_last = DIV4_LAST;
    endcase
  end

  // oscillator halts in sleep, so the master clock stops too
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_count <= 5'h00;
    end else if (mst_state == MS_IDLE || i_sleep || div_count == div_last) begin
      div_count <= 5'h00;
    end else begin
      div_count <= div_count + 5'h01;
    end
  end

  // each half period of the bit clock is one tick
  assign half_tick = (mst_state != MS_IDLE) & ~i_sleep &
                     ((mode_select == MODE_MASTER_TIMER) ? i_timer_tick
                                                         : (div_count == div_last));

  // ****************************************************************
  // master sequencer
  // ****************************************************************
  always_comb begin
    next_mst_state = mst_state;
    unique case (mst_state)
      MS_IDLE: begin
        if (master_en && (buf_write_ok || pin_direction[DIR_SCK_INPUT])) begin
          next_mst_state = MS_LEAD;
        end
      end
      MS_LEAD: begin
        if (half_tick) begin
          next_mst_state = MS_TRAIL;
        end
      end
      MS_TRAIL: begin
        if (half_tick) begin
          // receive-only master keeps clocking byte after byte
          if (bit_index == LAST_BIT_INDEX && !pin_direction[DIR_SCK_INPUT]) begin
            next_mst_state = MS_IDLE;
          end else begin
            next_mst_state = MS_LEAD;
          end
        end
      end
      default: next_mst_state = MS_IDLE;
    endcase
    if (!master_en) begin
      next_mst_state = MS_IDLE;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mst_state <= MS_IDLE;
    end else begin
      mst_state <= next_mst_state;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sck <= 1'b0;
    end else if (!master_en || mst_state == MS_IDLE) begin
      o_sck <= clock_polarity_bit;
    end else if (lead_pulse) begin
      o_sck <= ~clock_polarity_bit;
    end else if (trail_pulse) begin
      o_sck <= clock_polarity_bit;
    end
  end

  // ****************************************************************
  // edge selection: leading edge drives, trailing edge samples
  // ****************************************************************
  assign slave_edge  = slave_en & ss_active & (sck_sync != sck_prev);
  assign lead_pulse  = master_en ? ((mst_state == MS_LEAD) & half_tick)
                                 : (slave_edge & (sck_prev == clock_polarity_bit));
  assign trail_pulse = master_en ? ((mst_state == MS_TRAIL) & half_tick)
                                 : (slave_edge & (sck_prev != clock_polarity_bit));
  assign new_byte    = {serial_shift_reg[6:0], sdi_sync};
  assign shift_pulse = master_en ? sample_late : trail_pulse;
  assign byte_done   = shift_pulse & (bit_index == LAST_BIT_INDEX);

  // own clock is not synchronised but data-in is: at the fastest rate the
  // trailing edge comes before the new bit leaves the synchroniser
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sample_late <= 1'b0;
    end else begin
      sample_late <= master_en & trail_pulse;
    end
  end

  // ****************************************************************
  // shift register
  // ****************************************************************
  // select high freezes bit_index, so a later select low resumes
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      serial_shift_reg <= 8'h00;
      bit_index        <= 3'h0;
      o_sdo            <= 1'b0;
    end else if (!port_on) begin
      bit_index <= 3'h0;
    end else if (buf_write_ok) begin
      serial_shift_reg <= i_avs_writedata[7:0];
      bit_index        <= 3'h0;
    end else if (lead_pulse) begin
      o_sdo <= serial_shift_reg[7];
    end else if (shift_pulse) begin
      serial_shift_reg <= new_byte;
      bit_index        <= bit_index + 3'h1;
    end
  end

  // ****************************************************************
  // receive buffer and flags
  // ****************************************************************
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      serial_buffer <= SERIAL_BUFFER_RST;
    end else if (buf_write_ok) begin
      serial_buffer <= i_avs_writedata[7:0];
    end else if (byte_done && !(slave_en && buffer_full_flag)) begin
      serial_buffer <= new_byte;
    end
  end

  // a completion in the reading cycle keeps the flag set
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      buffer_full_flag <= SERIAL_STATUS_RST[STS_BUFFER_FULL];
    end else if (byte_done) begin
      buffer_full_flag <= 1'b1;
    end else if (rd_take && i_avs_address == IDX_SERIAL_BUFFER) begin
      buffer_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      receive_overflow_flag <= SERIAL_CONTROL_RST[CTL_RX_OVERFLOW];
    end else if (byte_done && slave_en && buffer_full_flag) begin
      receive_overflow_flag <= 1'b1;
    end else if (ctl_write) begin
      receive_overflow_flag <= i_avs_writedata[CTL_RX_OVERFLOW];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      write_collision_flag <= SERIAL_CONTROL_RST[CTL_WRITE_COLLISION];
    end else if (buf_write && in_progress) begin
      write_collision_flag <= 1'b1;
    end else if (ctl_write) begin
      write_collision_flag <= i_avs_writedata[CTL_WRITE_COLLISION];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_port_interrupt_flag <= 1'b0;
      o_wake                <= 1'b0;
    end else begin
      o_port_interrupt_flag <= byte_done;
      o_wake                <= byte_done & i_sleep;
    end
  end

  // ****************************************************************
  // pin ownership
  // ****************************************************************
  assign o_serial_pins_active = port_on;
  assign o_sck_oe_n = ~(master_en & ~pin_direction[DIR_SCK_INPUT]);
  assign o_sdo_oe_n = ~(port_on & ~pin_direction[DIR_SDO_INPUT] &
                        (master_en | ss_active));

endmodule

`default_nettype wire

// ==== tb/sps_port_checker_assertions.sv ====
// concurrent checks on the serial port ports: bus wait, pin enables, timing
// assumes it is bound to sps_serial_port and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module sps_port_checker
  import sps_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_sck,
  input wire logic        o_sck_oe_n,
  input wire logic        o_sdo_oe_n,
  input wire logic        i_slave_select_n,
  input wire logic        o_serial_pins_active,
  input wire logic        o_port_interrupt_flag,
  input wire logic        o_wake
);
  // ********
  // shadow of control and direction, taken from bus writes
  // ********
  logic [7:0] ctl;
  logic [3:0] dir;
  logic       busy;
  logic       tk;
  logic       st;
  logic       slv;

  assign tk  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  // only mode 0 with clock driven; slower rates are timed by the bench
  assign st  = tk && i_avs_address == IDX_SERIAL_BUFFER && ctl[5] && ctl[3:0] == 4'h0
               && !dir[0] && !busy;
  assign slv = ctl[5] && ctl[3:0] == 4'h4 && dir[3];

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl <= 8'h00;
      dir <= 4'hF;
    end else if (tk && i_avs_address == IDX_SERIAL_CONTROL) begin
      ctl <= i_avs_writedata[7:0];
    end else if (tk && i_avs_address == IDX_PIN_DIRECTION) begin
      dir <= i_avs_writedata[3:0];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
    end else if (o_port_interrupt_flag) begin
      busy <= 1'b0;
    end else if (st) begin
      busy <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  // ********
  // assertions
  // ********
  AST_WAIT_ONE: assert property ($rose(i_avs_read || i_avs_write) |->
    o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("bus wait not one cycle");
  AST_RD_HIGH: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
  AST_NO_OVF: assert property (i_avs_read && !o_avs_waitrequest && ctl[3:0] < 4'h4
    && i_avs_address == IDX_SERIAL_CONTROL |-> !o_avs_readdata[6])
    else $error("overflow seen in master mode");
  AST_PINS: assert property (o_serial_pins_active == (ctl[5] && ctl[3:0] <= 4'h5))
    else $error("pin ownership wrong");
  AST_SCK_OE: assert property (o_sck_oe_n == !(ctl[5] && ctl[3:0] <= 4'h3 && !dir[0]))
    else $error("clock pin enable wrong");
  AST_SDO_OE: assert property (!o_serial_pins_active || dir[2] |-> o_sdo_oe_n)
    else $error("data out driven while not allowed");
  AST_SS_FLOAT: assert property ((slv && i_slave_select_n)[*4] |-> o_sdo_oe_n)
    else $error("data out driven while deselected");
  AST_SS_DRIVE: assert property ((slv && !dir[2] && !i_slave_select_n)[*4] |->
    !o_sdo_oe_n) else $error("data out not driven while selected");
  AST_FREE: assert property (ctl[5] && ctl[3:0] == 4'h5 && !dir[2] |-> !o_sdo_oe_n)
    else $error("select pin used in mode 5");
  AST_START: assert property (st |-> ##[2:3] o_sck != ctl[4])
    else $error("clock did not start after write");
  AST_DONE: assert property (st |-> ##[33:34] o_port_interrupt_flag)
    else $error("byte time wrong at fastest rate");
  AST_IDLE: assert property (o_port_interrupt_flag && !o_sck_oe_n |-> o_sck == ctl[4])
    else $error("clock not at idle level after byte");
  AST_PULSE: assert property (o_port_interrupt_flag |=> !o_port_interrupt_flag)
    else $error("flag longer than one cycle");
  AST_WAKE: assert property (o_wake |-> o_port_interrupt_flag)
    else $error("wake without completed byte");
endmodule

bind sps_serial_port sps_port_checker i_chk (.i_clock, .i_arst_n, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
  .o_avs_waitrequest, .o_sck, .o_sck_oe_n, .o_sdo_oe_n, .i_slave_select_n,
  .o_serial_pins_active, .o_port_interrupt_flag, .o_wake);

`default_nettype wire

// ==== tb/sps_spi_partner.sv ====
// far-side SPI device: slave clocked by the block, or master via tasks
// assumes clock polarity 0 and the bench resolving shared wires
`timescale 1ns/1ps
`default_nettype none

module sps_spi_partner (
  input  wire logic i_clock,
  input  wire logic i_master,
  input  wire logic i_sck,
  input  wire logic i_sdo,
  output var  logic o_sck,
  output var  logic o_sdi,
  output var  logic o_ss_n
);
  // block synchronises its pins, so each clock phase lasts several cycles
  localparam int HALF = 6;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;

  initial begin
    o_sck  = 1'b0;
    o_sdi  = 1'b0;
    o_ss_n = 1'b1;
  end

  always @(posedge i_sck) begin
    if (!i_master) begin
      o_sdi <= tx[7];
      tx    <= {tx[6:0], ~tx[7]};
    end
  end

  always @(negedge i_sck) begin
    if (!i_master) begin
      rx <= {rx[6:0], i_sdo};
    end
  end

  // released data line keeps changing so stale bits are never mistaken
  always @(posedge i_clock) begin
    if (i_master && o_ss_n) begin
      o_sdi <= ~o_sdi;
    end
  end

  task automatic sel(input logic v);
    @(posedge i_clock);
    o_ss_n <= v;
    repeat (HALF) @(posedge i_clock);
  endtask

  task automatic mbits(input int n);
    repeat (n) begin
      o_sck <= 1'b1;
      o_sdi <= tx[7];
      tx    <= {tx[6:0], ~tx[7]};
      repeat (HALF) @(posedge i_clock);
      o_sck <= 1'b0;
      rx    <= {rx[6:0], i_sdo};
      repeat (HALF) @(posedge i_clock);
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the serial port block
// assumes the partner model on the serial side and one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sps_pkg::*;
  localparam int LIMIT = 20000;
  logic        i_clock = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  i_avs_address = 8'h00;
  logic        i_avs_read = 1'b0;
  logic        i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0]  i_avs_byteenable = 4'hF;
  logic        i_timer_tick = 1'b0;
  logic        i_sleep = 1'b0;
  logic        p_master = 1'b0;
  logic        sdo_q = 1'b0;
  logic        woke = 1'b0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, o_sck, o_sck_oe_n, o_sdo, o_sdo_oe_n;
  logic        o_serial_pins_active, o_port_interrupt_flag, o_wake;
  wire logic   sck_w, sdo_w, p_sck, p_sdi, p_ss_n;
  int          cyc = 0, nflag = 0, tflag = 0, miscompares = 0, num_checks = 0;

  assign sck_w = o_sck_oe_n ? p_sck : o_sck;
  assign sdo_w = o_sdo_oe_n ? ~sdo_q : o_sdo;

  sps_serial_port i_sps_serial_port (.i_clock, .i_arst_n, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
    .o_avs_waitrequest, .i_sck(sck_w), .o_sck, .o_sck_oe_n, .i_sdi(p_sdi), .o_sdo,
    .o_sdo_oe_n, .i_slave_select_n(p_ss_n), .i_timer_tick, .i_sleep,
    .o_serial_pins_active, .o_port_interrupt_flag, .o_wake);
  sps_spi_partner i_partner (.i_clock, .i_master(p_master), .i_sck(sck_w), .i_sdo(sdo_w),
    .o_sck(p_sck), .o_sdi(p_sdi), .o_ss_n(p_ss_n));

  always #5 i_clock = ~i_clock;

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    i_timer_tick <= (cyc % 4 == 3);
    if (!o_sdo_oe_n) sdo_q <= o_sdo;
    if (o_wake === 1'b1) woke <= 1'b1;
    if (o_port_interrupt_flag === 1'b1) begin
      nflag <= nflag + 1;
      tflag <= cyc;
    end
    if (cyc == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  // ********
  // shared tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge i_clock);
    i_avs_address   <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_read      <= !w;
    i_avs_write     <= w;
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    rdc(8'h14, 8'h00);
    rdc(8'h94, 8'h00);
    rdc(8'h20, 8'h00);
    chk(o_serial_pins_active, 32'h0);
    chk(o_sdo_oe_n, 32'h1);
    $display("t_reset done");
  endtask

  task automatic t_master;
    int h;
    int n0;
    int t0;
    for (int m = 0; m < 4; m++) begin
      h = (m == 0) ? 2 : (m == 1) ? 8 : (m == 2) ? 32 : 4;
      wr(8'h14, 8'h00);
      wr(8'h15, 8'h0A);
      wr(8'h14, 8'h20 | 8'(m));
      i_partner.tx = 8'h3C + 8'(m);
      n0 = nflag;
      wr(8'h13, 8'hA5 + 8'(m));
      t0 = cyc;
      wr(8'h13, 8'h55);
      wait (nflag != n0);
      // timer phase against the write is unknown by up to one tick period
      chk(tflag - t0 <= 16 * h + 2 && tflag - t0 >= ((m == 3) ? 16 * h - 1 : 16 * h + 2),
          32'h1);
      rdc(8'h14, 8'hA0 | 8'(m));
      rdc(8'h94, 8'h01);
      rdc(8'h13, 8'h3C + 8'(m));
      rdc(8'h94, 8'h00);
      chk(i_partner.rx, 8'hA5 + 8'(m));
    end
    $display("t_master done");
  endtask

  task automatic t_slave;
    int n0;
    p_master <= 1'b1;
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h0B);
    wr(8'h14, 8'h24);
    wr(8'h13, 8'hC3);
    i_partner.tx = 8'h5A;
    n0 = nflag;
    i_partner.sel(1'b0);
    i_partner.mbits(3);
    i_partner.sel(1'b1);
    chk(o_sdo_oe_n, 32'h1);
    i_partner.sel(1'b0);
    chk(o_sdo_oe_n, 32'h0);
    i_partner.mbits(5);
    wait (nflag != n0);
    rdc(8'h94, 8'h01);
    chk(i_partner.rx, 8'hC3);
    i_sleep <= 1'b1;
    n0 = nflag;
    i_partner.mbits(8);
    wait (nflag != n0);
    i_sleep <= 1'b0;
    i_partner.sel(1'b1);
    chk(woke, 32'h1);
    rdc(8'h14, 8'h64);
    rdc(8'h13, 8'h5A);
    rdc(8'h94, 8'h00);
    $display("t_slave done");
  endtask

  task automatic t_cfg;
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h0E);
    wr(8'h14, 8'h30);
    repeat (3) @(posedge i_clock);
    chk(o_sck, 32'h1);
    chk(o_sck_oe_n, 32'h0);
    chk(o_sdo_oe_n, 32'h1);
    wr(8'h20, 8'hFF);
    rdc(8'h14, 8'h30);
    wr(8'h14, 8'h10);
    @(posedge i_clock);
    chk(o_serial_pins_active, 32'h0);
    wr(8'h15, 8'h0B);
    wr(8'h14, 8'h25);
    @(posedge i_clock);
    chk(o_sdo_oe_n, 32'h0);
    i_avs_byteenable <= 4'hE;
    wr(8'h14, 8'h00);
    i_avs_byteenable <= 4'hF;
    rdc(8'h14, 8'h25);
    $display("t_cfg done");
  endtask

  initial begin
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    t_reset();
    t_master();
    t_slave();
    t_cfg();
    complete_run();
  end
endmodule

`default_nettype wire
